//--- include/tec_regs.svh
// register offsets, control field positions, reset values and count constants
// assumes one 8-bit register port; offsets are word indices on that port
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH

`define TEC_A_T0L   4'h0
`define TEC_A_T0H   4'h1
`define TEC_A_T1    4'h2
`define TEC_A_T2    4'h3
`define TEC_A_CTL0  4'h4
`define TEC_A_CTL1  4'h5
`define TEC_A_CTL2  4'h6
`define TEC_A_IEN   4'h7
`define TEC_A_FLAG  4'h8

`define TEC_B_MHI   7
`define TEC_B_MLO   6
`define TEC_B_CSEL  5
`define TEC_B_RUN   4
`define TEC_B_POL   3
`define TEC_B_PSCH  2
`define TEC_B_PSCL  0

`define TEC_CTL_RST  8'h00
`define TEC_CNT_RST  16'h0000
`define TEC_IEN_RST  3'h0

// system clock divided by eight for timer 0
`define TEC_DIV_LAST 3'h7

`endif

//--- include/tec_pkg.sv
// types shared by the timer/event counter block
// assumes tec_regs.svh is on the include path
`default_nettype none
package tec_pkg;

  typedef enum logic [1:0] {
    TEC_M_OFF   = 2'h0,
    TEC_M_EVENT = 2'h1,
    TEC_M_TIMER = 2'h2,
    TEC_M_PWM   = 2'h3
  } tec_mode_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic lvl;
  } tec_evt_t;

  typedef struct packed {
    logic     s1;
    logic     s2;
    tec_evt_t evt;
  } tec_sync_t;

  typedef struct packed {
    logic [2:0]       div;
    logic [7:0]       psc;
    logic [2:0][15:0] cnt;
    logic [2:0][15:0] pre;
    logic [2:0][7:0]  ctl;
    logic [7:0]       lowbuf;
    logic [7:0]       rdlatch;
    logic [2:0]       ien;
    logic [2:0]       flag;
    logic [1:0]       pw_act;
    logic [7:0]       rdata;
    logic [2:0]       irq;
    logic             wake;
  } tec_state_t;

endpackage
`default_nettype wire

//--- core/tec_pin_edge.sv
// input synchroniser with rise/fall detection for one timer pin
// assumes the pin may change at any time relative to core_clk
`default_nettype none
module tec_pin_edge
  import tec_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin_i,
  output tec_evt_t  evt
);

  tec_sync_t s_r;
  tec_sync_t s_nxt;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.s1       = pin_i;
    s_nxt.s2       = s_r.s1;
    s_nxt.evt.lvl  = s_r.s2;
    s_nxt.evt.rise = s_r.s2 & ~s_r.evt.lvl;
    s_nxt.evt.fall = ~s_r.s2 & s_r.evt.lvl;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign evt = s_r.evt;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_edge_exclusive: assert property (!(evt.rise && evt.fall))
    else $error("rise and fall flagged together");
  a_edge_follows: assert property ($rose(s_r.s2) |=> evt.rise)
    else $error("synchronised rise not flagged");

endmodule
`default_nettype wire

//--- core/tec_top.sv
// timer/event counters: one 16-bit and two 8-bit count-up counters
// assumes an 8-bit register port, one core clock, pins synchronous-safe
`include "tec_regs.svh"
`default_nettype none

module tec_top
  import tec_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic       timer0_input_pin,
  input  wire logic       timer1_count_or_pin,
  input  wire logic       slow_rc_clock,
  input  wire logic       pdown,
  output logic      [7:0] rdata,
  output logic      [2:0] irq_req,
  output logic            wake
);

  tec_state_t s_r;
  tec_state_t s_nxt;
  tec_evt_t   pin_evt [2];
  tec_evt_t   rc_evt;
  logic [2:0] tick_c;
  logic [2:0] ovf_c;
  logic [2:0] intclk_c;

  // falling edge of prescaler bit sel: divides by 2^(sel+1)
  function automatic logic psc_fall(input logic [7:0] c, input logic [2:0] sel);
    logic [7:0] ci;
    ci = c + 8'h01;
    return c[sel] & ~ci[sel];
  endfunction

  // one count step; 8-bit counters overflow at ff, the 16-bit one at ffff, reloading p
  function automatic logic [16:0] step(input logic [15:0] c,
                                       input logic [15:0] p,
                                       input logic        wide);
    logic full;
    full = wide ? (c == 16'hffff) : (c[7:0] == 8'hff);
    if (full) begin
      return {1'b1, p};
    end
    return {1'b0, c + 16'h0001};
  endfunction

  tec_pin_edge u_pin0 (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_i    (timer0_input_pin),
    .evt      (pin_evt[0])
  );

  tec_pin_edge u_pin1 (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_i    (timer1_count_or_pin),
    .evt      (pin_evt[1])
  );

  // the slow rc clock is treated as a sampled level, not a second domain
  tec_pin_edge u_rc (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_i    (slow_rc_clock),
    .evt      (rc_evt)
  );

  always_comb begin
    logic [2:0]  rd_inh;
    logic [2:0]  fset;
    logic [16:0] st;
    logic        run;
    logic        pol;
    logic        act_e;
    logic        ina_e;
    tec_mode_t   md;
    rd_inh   = 3'h0;
    fset     = 3'h0;
    st       = 17'h00000;
    run      = 1'b0;
    pol      = 1'b0;
    act_e    = 1'b0;
    ina_e    = 1'b0;
    md       = TEC_M_OFF;
    tick_c   = 3'h0;
    ovf_c    = 3'h0;
    s_nxt    = s_r;
    s_nxt.rdata = 8'h00;
    s_nxt.wake  = 1'b0;
    s_nxt.div   = s_r.div + 3'h1;
    s_nxt.psc   = s_r.psc + 8'h01;

    // timer 0 source, bit 5 high picks the slow rc clock
    // the divide-by-eight clock falls as div wraps to zero
    intclk_c[0] = s_r.ctl[0][`TEC_B_CSEL] ? rc_evt.fall : (s_r.div == `TEC_DIV_LAST);
    // prescaled internal clock for the 8-bit timers
    intclk_c[1] = psc_fall(s_r.psc, s_r.ctl[1][`TEC_B_PSCH:`TEC_B_PSCL]);
    intclk_c[2] = psc_fall(s_r.psc, s_r.ctl[2][`TEC_B_PSCH:`TEC_B_PSCL]);

    // a counter read holds its clock off for that cycle
    if (rd_en) begin
      rd_inh[0] = (addr == `TEC_A_T0L) || (addr == `TEC_A_T0H);
      rd_inh[1] = (addr == `TEC_A_T1);
      rd_inh[2] = (addr == `TEC_A_T2);
    end

    for (int i = 0; i < 2; i++) begin
      // mode field in the top two control bits
      md  = tec_mode_t'(s_r.ctl[i][`TEC_B_MHI:`TEC_B_MLO]);
      run = s_r.ctl[i][`TEC_B_RUN];
      // polarity applies to event and pulse width modes
      pol = s_r.ctl[i][`TEC_B_POL];
      // polarity zero counts rising edges, one counts falling
      act_e = pol ? pin_evt[i].fall : pin_evt[i].rise;
      ina_e = pol ? pin_evt[i].rise : pin_evt[i].fall;
      case (md)
        // timer mode counts the internal clock
        TEC_M_TIMER: tick_c[i] = intclk_c[i] & ~pdown;
        // pin events still count during power-down
        TEC_M_EVENT: tick_c[i] = act_e;
        // internal clock gated by the pin's active level
        TEC_M_PWM:   tick_c[i] = intclk_c[i] & s_r.pw_act[i] & ~pdown;
        default:     tick_c[i] = 1'b0;
      endcase
      // nothing advances unless run is set
      tick_c[i] = tick_c[i] & run & ~rd_inh[i];

      // a pulse leads with the edge event mode ignores, ends on the counted one
      if ((md != TEC_M_PWM) || !run) begin
        s_nxt.pw_act[i] = 1'b0;
      end else if (!s_r.pw_act[i] && ina_e) begin
        s_nxt.pw_act[i] = 1'b1;
      end else if (s_r.pw_act[i] && act_e) begin
        s_nxt.pw_act[i] = 1'b0;
        s_nxt.ctl[i][`TEC_B_RUN] = 1'b0;
      end
    end

    // timer 2 only ever runs as a plain timer
    tick_c[2] = intclk_c[2] & ~pdown & s_r.ctl[2][`TEC_B_RUN] & ~rd_inh[2];

    // count up, reload on overflow, raise the event
    for (int i = 0; i < 3; i++) begin
      st = step(s_r.cnt[i], s_r.pre[i], (i == 0));
      if (tick_c[i]) begin
        s_nxt.cnt[i] = st[15:0];
        ovf_c[i]     = st[16];
      end
    end
    // every overflow sets its request flag
    fset = ovf_c;
    // overflow in power-down wakes, whatever the enables
    s_nxt.wake = pdown & (|ovf_c);

    if (wr_en) begin
      case (addr)
        // low byte only reaches the holding buffer
        `TEC_A_T0L: s_nxt.lowbuf = wdata;
        `TEC_A_T0H: begin
          // high byte plus buffered low byte together
          s_nxt.pre[0] = {wdata, s_r.lowbuf};
          // running counter keeps going until overflow
          if (!s_r.ctl[0][`TEC_B_RUN]) begin
            s_nxt.cnt[0] = {wdata, s_r.lowbuf};
          end
        end
        `TEC_A_T1: begin
          s_nxt.pre[1] = {8'h00, wdata};
          if (!s_r.ctl[1][`TEC_B_RUN]) begin
            s_nxt.cnt[1] = {8'h00, wdata};
          end
        end
        `TEC_A_T2: begin
          s_nxt.pre[2] = {8'h00, wdata};
          if (!s_r.ctl[2][`TEC_B_RUN]) begin
            s_nxt.cnt[2] = {8'h00, wdata};
          end
        end
        // a software write of run overrides the automatic clear
        `TEC_A_CTL0: s_nxt.ctl[0] = wdata;
        `TEC_A_CTL1: s_nxt.ctl[1] = wdata;
        `TEC_A_CTL2: s_nxt.ctl[2] = wdata;
        `TEC_A_IEN:  s_nxt.ien = wdata[2:0];
        default:     s_nxt.ien = s_nxt.ien;
      endcase
    end

    // write one to clear; a same-cycle overflow still wins
    if (wr_en && (addr == `TEC_A_FLAG)) begin
      s_nxt.flag = (s_r.flag & ~wdata[2:0]) | fset;
    end else begin
      s_nxt.flag = s_r.flag | fset;
    end

    if (rd_en) begin
      case (addr)
        // low byte reads return the latched copy
        `TEC_A_T0L: s_nxt.rdata = s_r.rdlatch;
        `TEC_A_T0H: begin
          // high byte read captures the low byte
          s_nxt.rdata   = s_r.cnt[0][15:8];
          s_nxt.rdlatch = s_r.cnt[0][7:0];
        end
        `TEC_A_T1:   s_nxt.rdata = s_r.cnt[1][7:0];
        `TEC_A_T2:   s_nxt.rdata = s_r.cnt[2][7:0];
        `TEC_A_CTL0: s_nxt.rdata = s_r.ctl[0];
        `TEC_A_CTL1: s_nxt.rdata = s_r.ctl[1];
        `TEC_A_CTL2: s_nxt.rdata = s_r.ctl[2];
        `TEC_A_IEN:  s_nxt.rdata = {5'h00, s_r.ien};
        `TEC_A_FLAG: s_nxt.rdata = {5'h00, s_r.flag};
        default:     s_nxt.rdata = 8'h00;
      endcase
    end

    // request only where the enable is set
    s_nxt.irq = s_nxt.flag & s_nxt.ien;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r     <= '0;
      s_r.ctl <= {3{`TEC_CTL_RST}};
      s_r.cnt <= {3{`TEC_CNT_RST}};
      s_r.pre <= {3{`TEC_CNT_RST}};
      s_r.ien <= `TEC_IEN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata   = s_r.rdata;
  assign irq_req = s_r.irq;
  assign wake    = s_r.wake;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_high_read_data: assert property (
    rd_en && (addr == `TEC_A_T0H)
    |=> (rdata == $past(s_r.cnt[0][15:8])) && (s_r.rdlatch == $past(s_r.cnt[0][7:0])))
    else $error("high byte read wrong or low byte not latched");

  a_low_read_latch: assert property (
    rd_en && (addr == `TEC_A_T0L) |=> rdata == $past(s_r.rdlatch))
    else $error("low byte read not from latch");

  a_stopped_holds: assert property (
    !s_r.ctl[0][`TEC_B_RUN] && !wr_en |=> $stable(s_r.cnt[0]))
    else $error("stopped timer 0 moved");

  a_low_write_buf: assert property (
    wr_en && (addr == `TEC_A_T0L) && !s_r.ctl[0][`TEC_B_RUN]
    |=> $stable(s_r.cnt[0]) && (s_r.lowbuf == $past(wdata)))
    else $error("low byte write reached the counter");

  a_high_write_load: assert property (
    wr_en && (addr == `TEC_A_T0H) && !s_r.ctl[0][`TEC_B_RUN]
    |=> s_r.cnt[0] == {$past(wdata), $past(s_r.lowbuf)})
    else $error("stopped 16-bit load wrong");

  a_run_preload_only: assert property (
    wr_en && (addr == `TEC_A_T1) && s_r.ctl[1][`TEC_B_RUN] && !tick_c[1]
    |=> $stable(s_r.cnt[1]) && (s_r.pre[1][7:0] == $past(wdata)))
    else $error("running preload write touched the counter");

  a_read_inhibit: assert property (
    rd_en && (addr == `TEC_A_T1) |=> $stable(s_r.cnt[1]))
    else $error("counter moved during its read");

  a_ovf_reload: assert property (
    tick_c[1] && (s_r.cnt[1][7:0] == 8'hff) && !wr_en
    |=> (s_r.cnt[1] == $past(s_r.pre[1])) && s_r.flag[1])
    else $error("8-bit overflow did not reload and flag");

  a_irq_gating: assert property (
    ##1 irq_req == (s_r.flag & s_r.ien))
    else $error("interrupt request not flag and enable");

  a_pwm_run_clear: assert property (
    (s_r.ctl[1][`TEC_B_MHI:`TEC_B_MLO] == TEC_M_PWM) && s_r.ctl[1][`TEC_B_RUN]
    && s_r.pw_act[1] && (s_r.ctl[1][`TEC_B_POL] ? pin_evt[1].fall : pin_evt[1].rise)
    && !wr_en |=> !s_r.ctl[1][`TEC_B_RUN] ##1 $stable(s_r.cnt[1]))
    else $error("pulse width end did not stop the timer");

  a_wake_pdown: assert property (
    (ovf_c != 3'h0) && pdown && !(wr_en && (addr == `TEC_A_FLAG))
    |=> wake && (s_r.flag == ($past(s_r.flag) | $past(ovf_c))))
    else $error("overflow in power-down did not wake");

  a_event_pdown: assert property (
    tick_c[0] && pdown |-> (s_r.ctl[0][`TEC_B_MHI:`TEC_B_MLO] == TEC_M_EVENT))
    else $error("non-event counting during power-down");

endmodule
`default_nettype wire

//--- verification/tec_pin_model.sv
// external event source for one timer input pin
// assumes core_clk is the bench clock; go is a one-cycle request
`default_nettype none
module tec_pin_model (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [3:0] toggles,
  output logic            pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // each level is held four cycles so the two-flop synchroniser sees every one
  localparam int HOLD = 4;
  logic [3:0] left;
  logic [3:0] age;
  initial begin
    pin  = 1'b0;
    left = 4'h0;
    age  = 4'h0;
  end
  assign busy = (left != 4'h0);
  always @(posedge core_clk) begin
    if (go) begin
      left <= toggles;
      age  <= 4'h0;
    end else if (left != 4'h0) begin
      if (age == 4'(HOLD - 1)) begin
        pin  <= ~pin;
        left <= left - 4'h1;
        age  <= 4'h0;
      end else begin
        age <= age + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/tec_top_tb.sv
// self-checking bench for the timer/event counters
// assumes the register map of tec_regs.svh and one 125 MHz core clock
`include "tec_regs.svh"
`default_nettype none
module tec_top_tb
  import tec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0;
  logic       rst      = 1'b1;
  logic       wr_en    = 1'b0;
  logic       rd_en    = 1'b0;
  logic       pdown    = 1'b0;
  logic       rc       = 1'b0;
  logic [3:0] addr     = 4'h0;
  logic [7:0] wdata    = 8'h00;
  logic       go0      = 1'b0;
  logic       go1      = 1'b0;
  logic [3:0] tg       = 4'h0;
  logic [7:0] rdata, v, h;
  logic [2:0] irq_req;
  logic       wake, pin0, pin1, busy0, busy1;
  int         n_errors = 0;
  int         checks   = 0;

  always #4 core_clk = ~core_clk;

  tec_top dut_u (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .timer0_input_pin(pin0), .timer1_count_or_pin(pin1),
    .slow_rc_clock(rc), .pdown(pdown), .rdata(rdata), .irq_req(irq_req), .wake(wake));
  tec_pin_model pin0_u (.core_clk(core_clk), .go(go0), .toggles(tg), .pin(pin0),
    .busy(busy0));
  tec_pin_model pin1_u (.core_clk(core_clk), .go(go1), .toggles(tg), .pin(pin1),
    .busy(busy1));

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // sel 3 watches wake, otherwise one irq_req bit; a wake pulse lasts one cycle
  task automatic wait_for(input int sel, input int bound);
    int n;
    n = 0;
    while (((sel == 3) ? wake : irq_req[sel]) !== 1'b1) begin
      if (n == bound) begin
        n_errors++;
        $display("ERROR wait %0d expected 1 seen timeout", sel);
        results();
      end
      @(posedge core_clk);
      #1 n++;
    end
  endtask

  // one request to a pin model; busy is only visible one edge after go is taken
  task automatic toggle_pin(input logic sel, input logic [3:0] n);
    int k;
    k = 0;
    @(posedge core_clk);
    tg  <= n;
    go0 <= ~sel;
    go1 <= sel;
    @(posedge core_clk);
    go0 <= 1'b0;
    go1 <= 1'b0;
    @(posedge core_clk);
    while ((sel ? busy1 : busy0) !== 1'b0) begin
      if (k == 80) begin
        n_errors++;
        $display("ERROR pin model expected idle seen busy");
        results();
      end
      @(posedge core_clk);
      k++;
    end
  endtask

  task automatic t_reset;
    for (int i = 0; i < 10; i++) begin
      rd(4'(i), v);
      chk("reset value", {8'h00, v}, 16'h0000);
    end
    $display("test reset done");
  endtask

  task automatic t_wide;
    // software order: low byte first on write, high byte first on read
    wr(`TEC_A_T0L, 8'h34);
    rd(`TEC_A_T0H, h);
    rd(`TEC_A_T0L, v);
    chk("t0 after low write", {h, v}, 16'h0000);
    wr(`TEC_A_T0H, 8'h12);
    rd(`TEC_A_T0H, h);
    rd(`TEC_A_T0L, v);
    chk("t0 after high write", {h, v}, 16'h1234);
    $display("test wide done");
  endtask

  task automatic t_halt;
    wr(`TEC_A_T2, 8'h40);
    wr(`TEC_A_CTL2, 8'h80);
    repeat (40) @(posedge core_clk);
    rd(`TEC_A_T2, v);
    chk("t2 halted", {8'h00, v}, 16'h0040);
    wr(`TEC_A_CTL2, 8'h90);
    wait_for(2, 1000);
    chk("t2 irq", {13'h0, irq_req}, 16'h0004);
    wr(`TEC_A_CTL2, 8'h00);
    wr(`TEC_A_FLAG, 8'h04);
    $display("test halt done");
  endtask

  task automatic t_timer;
    wr(`TEC_A_T1, 8'hff);
    wr(`TEC_A_CTL1, 8'h97);
    // preload while running: the counter must wait for overflow to take it
    wr(`TEC_A_T1, 8'h10);
    wait_for(1, 700);
    rd(`TEC_A_T1, v);
    chk("t1 reload", {8'h00, v}, 16'h0010);
    rd(`TEC_A_FLAG, v);
    chk("flags", {8'h00, v}, 16'h0002);
    wr(`TEC_A_FLAG, 8'h02);
    #1 chk("irq cleared", {13'h0, irq_req}, 16'h0000);
    wr(`TEC_A_CTL1, 8'h00);
    $display("test timer done");
  endtask

  task automatic t_event;
    wr(`TEC_A_T1, 8'hfd);
    wr(`TEC_A_CTL1, 8'h58);
    toggle_pin(1'b1, 4'h3);
    repeat (6) @(posedge core_clk);
    // three toggles from low give two rises and one fall
    rd(`TEC_A_T1, v);
    chk("t1 falling count", {8'h00, v}, 16'h00fe);
    wr(`TEC_A_T0L, 8'hff);
    wr(`TEC_A_T0H, 8'hff);
    wr(`TEC_A_CTL0, 8'h50);
    @(posedge core_clk);
    pdown <= 1'b1;
    toggle_pin(1'b0, 4'h1);
    wait_for(3, 40);
    chk("wake in power-down", {15'h0, wake}, 16'h0001);
    #8 chk("t0 irq", {13'h0, irq_req}, 16'h0001);
    @(posedge core_clk);
    pdown <= 1'b0;
    rd(`TEC_A_T0H, h);
    rd(`TEC_A_T0L, v);
    chk("t0 reload", {h, v}, 16'hffff);
    $display("test event done");
  endtask

  task automatic t_pwm;
    wr(`TEC_A_CTL1, 8'h00);
    wr(`TEC_A_T1, 8'h20);
    wr(`TEC_A_CTL1, 8'hd0);
    // pin idles high here; a four-cycle low pulse spans exactly two divide-by-two ticks
    toggle_pin(1'b1, 4'h2);
    repeat (6) @(posedge core_clk);
    rd(`TEC_A_CTL1, v);
    chk("pwm run cleared", {8'h00, v}, 16'h00c0);
    rd(`TEC_A_T1, v);
    chk("pwm width", {8'h00, v}, 16'h0022);
    $display("test pwm done");
  endtask

  task automatic t_rc;
    wr(`TEC_A_CTL0, 8'h00);
    wr(`TEC_A_T0L, 8'h00);
    wr(`TEC_A_T0H, 8'h00);
    // 64 cycles of run on the divide-by-eight clock give exactly eight ticks
    wr(`TEC_A_CTL0, 8'h90);
    repeat (62) @(posedge core_clk);
    wr(`TEC_A_CTL0, 8'h00);
    rd(`TEC_A_T0H, h);
    rd(`TEC_A_T0L, v);
    chk("t0 core clock count", {h, v}, 16'h0008);
    // four slow clock periods, each level held long enough to pass the synchroniser
    wr(`TEC_A_CTL0, 8'hb0);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      rc <= 1'b1;
      repeat (4) @(posedge core_clk);
      rc <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    wr(`TEC_A_CTL0, 8'h00);
    rd(`TEC_A_T0H, h);
    rd(`TEC_A_T0L, v);
    chk("t0 slow clock count", {h, v}, 16'h000c);
    $display("test rc done");
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    wr(`TEC_A_IEN, 8'h07);
    t_wide();
    t_halt();
    t_timer();
    t_event();
    t_pwm();
    t_rc();
    results();
  end
endmodule
`default_nettype wire
